// >>> core/hdlcam_core.sv
// Overview of operation
// RULE1: high address byte compared against both programmed high match values.
// RULE2: mask bits exclude address bits from high and low comparisons.
// RULE3: interpretation bit 1 reports C/R 0 as command; bit 0 reverses.
// RULE4: software sets first high register to zero in auto one-byte mode.
// RULE5: modulo select picks one-byte modulo 8 or two-byte modulo 128 control.
// RULE6: first low match register write-only in auto and non-auto modes.
// RULE7: second low match register is second low address or response address.
// RULE8: transparent mode 1 reads byte after high address; writes ignored.
// RULE9: transparent mode 0 reads first byte after flag; writes ignored.
// RULE10: extended transparent reads byte being assembled from receive pin.
// RULE11: control field of last frame captured and written into receive queue.
// RULE12: supervisory frames in auto mode handled inside, not passed to host.
// RULE13: modulo 128 unnumbered frames keep control field as in modulo 8.
// RULE14: modulo 128 information frames stored compressed, bit 0 cleared.
// RULE15: received length 1..4095 reported as 12 bits over two registers.
// RULE16: low five count bits give valid bytes held in receive queue.
// RULE17: count overflow flag set when frame exceeds 4095 bytes.
// RULE18: DMA transmit requests programmed count plus one transfers after command.
// RULE19: transfer mode bit picks interrupt or DMA; reads back with HALF_DUPLEX_RESPONSE, CAS.
// RULE20: response mode bit picks full duplex or half-duplex normal response.
// RULE21: carrier auto start lets carrier enable receiver; else general input.
// RULE22: continuous transmit in DMA mode requests without limit.
// RULE23: operating select encodes auto, non-auto, transparent, extended transparent.
// RULE24: address length select picks 8-bit or 16-bit address field.
`default_nettype none
module hdlcam_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire hdlcam_pkg::hdlcam_rx_s rx_in,
  input wire logic rxd_bit,
  input wire logic rxd_strobe,
  input wire logic carrier_sense_pin,
  input wire logic [2:0] clock_mode,
  input wire logic tx_info_frame_cmd,
  input wire logic tx_transparent_frame_cmd,
  input wire logic dma_ack,
  output logic dma_req,
  output logic receiver_enable,
  output logic half_duplex_response,
  output logic rx_frame_end_event,
  output logic sup_frame_event,
  output logic rx_queue_wr,
  output logic [7:0] rx_queue_data
);
  import hdlcam_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic fld_match(input logic [7:0] rx, input logic [7:0] ref_v,
                                     input logic [7:0] mask, input logic [7:0] care);
    return (((rx ^ ref_v) & ~mask & care) == 8'h00);
  endfunction

  function automatic logic [7:0] compress_ctrl(input logic [7:0] c0, input logic [7:0] c1);
    return {c1[3:1], c1[0], c0[3:1], 1'b0};
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] mode_reg, high_match_first_reg, high_match_second_reg, low_match_first_reg, low_match_second_reg, amh_reg, aml_reg;
  logic [7:0] tx_length_low_reg, tx_length_high_reg, ctrl_reg, low_match_first_rx_reg, ext_shift_reg;
  logic [7:0] c0_reg, c1_reg;
  logic [12:0] len_reg;
  logic [11:0] rbc_reg;
  logic ov_reg, in_frame_reg, high_ok_reg, low_ok_reg, la_reg, cmd_reg;
  logic [1:0] ha_reg;
  logic [2:0] bidx_reg;
  hdlcam_op_e op;
  logic addr_length_select, modulo_select, cmd_resp_invert, dma_mode, endless, cas, gp_in;
  logic has_high, has_low, two_ctrl;
  logic [2:0] low_pos, ctrl_pos, cap_pos;
  logic byte_in, frame_end, sframe, accepted;
  logic [7:0] ctrl_val, rx_d;

  assign op = hdlcam_op_e'(mode_reg[MODE_OPS_HI:MODE_OPS_LO]); // see RULE23
  assign addr_length_select = mode_reg[MODE_ADM];
  assign modulo_select = high_match_second_reg[HIGH_MATCH_SECOND_MCS];
  assign cmd_resp_invert = high_match_first_reg[HIGH_MATCH_FIRST_CRI];
  assign dma_mode = tx_length_high_reg[TX_LENGTH_HIGH_DMA]; // see RULE19
  assign endless = dma_mode && tx_length_high_reg[TX_LENGTH_HIGH_XC]; // see RULE22
  assign cas = tx_length_high_reg[TX_LENGTH_HIGH_CAS];
  assign half_duplex_response = (op == OP_AUTO) && tx_length_high_reg[TX_LENGTH_HIGH_NRM]; // see RULE20
  assign rx_d = rx_in.data;

  // ---------------------------------------------------------------
  // frame field layout per mode
  // ---------------------------------------------------------------
  always_comb begin
    has_low = (op == OP_AUTO) || (op == OP_NONAUTO);
    has_high = (has_low || (op == OP_TRANSP)) && addr_length_select; // see RULE24
    low_pos = addr_length_select ? 3'h1 : 3'h0;
    cap_pos = addr_length_select ? 3'h1 : 3'h0;
    if (has_low) begin
      ctrl_pos = addr_length_select ? 3'h2 : 3'h1;
    end else begin
      ctrl_pos = addr_length_select ? 3'h2 : 3'h1;
    end
    two_ctrl = (op == OP_AUTO) && modulo_select; // see RULE5
  end

  assign byte_in = rx_in.valid && in_frame_reg && (op != OP_EXT);
  assign frame_end = rx_in.last && in_frame_reg && (op != OP_EXT);
  assign sframe = (op == OP_AUTO) && (c0_reg[1:0] == 2'b01);
  assign accepted = high_ok_reg && low_ok_reg;
  // compressed form only for information frames
  assign ctrl_val = (two_ctrl && !c0_reg[0]) ? compress_ctrl(c0_reg, c1_reg) // see RULE14
                                             : c0_reg; // see RULE13

  // ---------------------------------------------------------------
  // receive address recognition and capture
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame_reg <= 1'b0;
      bidx_reg <= 3'h0;
      high_ok_reg <= 1'b0;
      low_ok_reg <= 1'b0;
      ha_reg <= 2'b11;
      la_reg <= 1'b0;
      cmd_reg <= 1'b0;
      c0_reg <= REG_RST;
      c1_reg <= REG_RST;
      low_match_first_rx_reg <= REG_RST;
    end else if (rx_in.start && (op != OP_EXT)) begin
      in_frame_reg <= 1'b1;
      bidx_reg <= 3'h0;
      high_ok_reg <= 1'b1;
      low_ok_reg <= 1'b1;
    end else begin
      if (frame_end) begin
        in_frame_reg <= 1'b0;
      end
      if (byte_in) begin
        if (bidx_reg != 3'h7) begin
          bidx_reg <= bidx_reg + 3'h1;
        end
        if (has_high && (bidx_reg == 3'h0)) begin
          cmd_reg <= rx_d[1] ^ cmd_resp_invert; // see RULE3
          if (fld_match(rx_d, high_match_first_reg, amh_reg, HIGH_CARE)) begin // see RULE1, RULE2
            ha_reg <= 2'b10;
          end else if (fld_match(rx_d, high_match_second_reg, amh_reg, HIGH_CARE)) begin // see RULE1
            ha_reg <= 2'b00;
          end else if (fld_match(rx_d, HIGH_BCAST, 8'h00, HIGH_CARE)) begin
            ha_reg <= 2'b01;
          end else begin
            ha_reg <= 2'b11;
            high_ok_reg <= 1'b0;
          end
        end
        if (has_low && (bidx_reg == low_pos)) begin
          if (fld_match(rx_d, low_match_first_reg, aml_reg, LOW_CARE)) begin // see RULE2, RULE6
            la_reg <= 1'b1;
          end else if (fld_match(rx_d, low_match_second_reg, aml_reg, LOW_CARE)) begin // see RULE7
            la_reg <= 1'b0;
          end else begin
            low_ok_reg <= 1'b0;
          end
        end
        if ((op == OP_TRANSP) && (bidx_reg == cap_pos)) begin
          low_match_first_rx_reg <= rx_d; // see RULE8, RULE9
        end
        if (bidx_reg == ctrl_pos) begin
          c0_reg <= rx_d;
        end
        if (two_ctrl && (bidx_reg == ctrl_pos + 3'h1)) begin
          c1_reg <= rx_d; // see RULE5
        end
      end
    end
  end

  // extended transparent: bits shift in lsb first, framing bypassed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_shift_reg <= REG_RST;
    end else if (rxd_strobe && (op == OP_EXT)) begin
      ext_shift_reg <= {rxd_bit, ext_shift_reg[7:1]}; // see RULE10
    end
  end

  // ---------------------------------------------------------------
  // byte count and end of frame
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_reg <= LEN_RST;
      rbc_reg <= 12'h000;
      ov_reg <= 1'b0;
      ctrl_reg <= REG_RST;
      rx_frame_end_event <= 1'b0;
      sup_frame_event <= 1'b0;
      rx_queue_wr <= 1'b0;
      rx_queue_data <= REG_RST;
    end else begin
      rx_frame_end_event <= 1'b0;
      sup_frame_event <= 1'b0;
      rx_queue_wr <= 1'b0;
      if (rx_in.start && (op != OP_EXT)) begin
        len_reg <= LEN_RST;
      end else if (byte_in && !len_reg[12]) begin
        len_reg <= len_reg + 13'h0001;
      end
      if (frame_end && accepted) begin
        if (sframe) begin
          sup_frame_event <= 1'b1; // see RULE12
        end else begin
          rbc_reg <= len_reg[11:0]; // see RULE15, RULE16
          ov_reg <= len_reg[12]; // see RULE17
          ctrl_reg <= ctrl_val; // see RULE11
          rx_queue_wr <= 1'b1; // see RULE11
          rx_queue_data <= ctrl_val;
          rx_frame_end_event <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // carrier auto start
  // ---------------------------------------------------------------
  assign receiver_enable = cas ? carrier_sense_pin : mode_reg[MODE_RAC]; // see RULE21
  assign gp_in = !cas && (clock_mode != CLK_MODE_A) && (clock_mode != CLK_MODE_B)
                 && carrier_sense_pin; // see RULE21

  // ---------------------------------------------------------------
  // transmit DMA request counting
  // ---------------------------------------------------------------
  hdlcam_tx_e tx_state;
  logic [12:0] remain_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      remain_reg <= LEN_RST;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if ((tx_info_frame_cmd || tx_transparent_frame_cmd) && dma_mode) begin
            remain_reg <= {1'b0, tx_length_high_reg[3:0], tx_length_low_reg} + 13'h0001; // see RULE18
            tx_state <= TX_REQ;
          end
        end
        TX_REQ: begin
          if (!dma_mode) begin
            tx_state <= TX_IDLE;
          end else if (dma_ack && !endless) begin // see RULE22
            remain_reg <= remain_reg - 13'h0001;
            if (remain_reg == 13'h0001) begin
              tx_state <= TX_IDLE; // see RULE18
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  assign dma_req = (tx_state == TX_REQ);

  // ---------------------------------------------------------------
  // AXI4-Lite write
  // ---------------------------------------------------------------
  logic aw_held_reg, w_held_reg, wr_en;
  logic [7:0] awaddr_reg, wbyte_reg;
  logic wstrb0_reg;
  logic [5:0] wr_idx;
  logic wr_map, low_match_first_wr;

  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign wr_en = aw_held_reg && w_held_reg && !bvalid;
  assign wr_idx = awaddr_reg[7:2];
  assign low_match_first_wr = (op == OP_AUTO) || (op == OP_NONAUTO); // see RULE8, RULE9, RULE10

  always_comb begin
    case (wr_idx)
      IDX_MODE, IDX_HIGH_MATCH_FIRST, IDX_HIGH_MATCH_SECOND, IDX_LOW_MATCH_FIRST, IDX_CTRL, IDX_LENL, IDX_LENH,
      IDX_AMH, IDX_AML, IDX_STAT: wr_map = (awaddr_reg[1:0] == 2'b00);
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wstrb0_reg <= wstrb[0];
      end
      if (wr_en) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= REG_RST;
      high_match_first_reg <= REG_RST;
      high_match_second_reg <= REG_RST;
      low_match_first_reg <= REG_RST;
      low_match_second_reg <= REG_RST;
      amh_reg <= REG_RST;
      aml_reg <= REG_RST;
      tx_length_low_reg <= REG_RST;
      tx_length_high_reg <= REG_RST;
    end else if (wr_en && wr_map && wstrb0_reg) begin
      case (wr_idx)
        IDX_MODE: mode_reg <= wbyte_reg;
        IDX_HIGH_MATCH_FIRST: high_match_first_reg <= wbyte_reg; // see RULE4
        IDX_HIGH_MATCH_SECOND: high_match_second_reg <= wbyte_reg;
        IDX_LOW_MATCH_FIRST: begin
          if (low_match_first_wr) begin
            low_match_first_reg <= wbyte_reg; // see RULE6
          end
        end
        IDX_CTRL: low_match_second_reg <= wbyte_reg; // see RULE7
        IDX_LENL: tx_length_low_reg <= wbyte_reg;
        IDX_LENH: tx_length_high_reg <= wbyte_reg;
        IDX_AMH: amh_reg <= wbyte_reg;
        IDX_AML: aml_reg <= wbyte_reg;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read
  // ---------------------------------------------------------------
  logic [7:0] rd_val;
  logic rd_map;

  assign arready = !rvalid;

  always_comb begin
    rd_val = 8'h00;
    rd_map = (araddr[1:0] == 2'b00);
    case (araddr[7:2])
      IDX_MODE: rd_val = mode_reg;
      IDX_HIGH_MATCH_FIRST, IDX_HIGH_MATCH_SECOND: rd_val = 8'h00;
      IDX_LOW_MATCH_FIRST: begin
        if (op == OP_EXT) begin
          rd_val = ext_shift_reg; // see RULE10
        end else if (op == OP_TRANSP) begin
          rd_val = low_match_first_rx_reg; // see RULE8, RULE9
        end else begin
          rd_val = 8'h00; // see RULE6
        end
      end
      IDX_CTRL: rd_val = ctrl_reg;
      IDX_LENL: rd_val = rbc_reg[7:0]; // see RULE15
      IDX_LENH: rd_val = {tx_length_high_reg[7:5], ov_reg, rbc_reg[11:8]}; // see RULE19
      IDX_AMH: rd_val = amh_reg;
      IDX_AML: rd_val = aml_reg;
      IDX_STAT: begin
        rd_val[STAT_GPIN] = gp_in;
        rd_val[STAT_RXEN] = receiver_enable;
        rd_val[STAT_LA] = la_reg;
        rd_val[STAT_CMD] = cmd_reg;
        rd_val[1:0] = ha_reg;
      end
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_map ? rd_val : 8'h00};
      rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WR_RESP: assert property (wr_en |=> bvalid && !awready && !wready) // see RULE19
    else $error("write response not raised after address and data");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid [*1] ##0 !arready)
    else $error("read answer missing");
  AST_DMA_COUNT: assert property ((tx_state == TX_IDLE) && tx_info_frame_cmd && dma_mode
      |=> dma_req && (remain_reg == {1'b0, $past(tx_length_high_reg[3:0]), $past(tx_length_low_reg)} + 13'h0001)) // see RULE18
    else $error("dma request count not programmed count plus one");
  AST_ENDLESS: assert property (dma_req && endless |=> dma_req && $stable(remain_reg)) // see RULE22
    else $error("continuous transmit stopped requesting");
  AST_OVERFLOW: assert property (frame_end && accepted && !sframe && len_reg[12]
      |=> ov_reg && (rbc_reg == 12'h000)) // see RULE17
    else $error("overflow flag not set above 4095 bytes");
  AST_SFRAME: assert property (frame_end && accepted && sframe
      |=> sup_frame_event && !rx_queue_wr && !rx_frame_end_event) // see RULE12
    else $error("supervisory frame passed to host");
  AST_QUEUE_CTRL: assert property (rx_queue_wr |-> rx_queue_data == ctrl_reg) // see RULE11
    else $error("queue control byte differs from captured field");
  AST_CMD_RESP: assert property (byte_in && has_high && (bidx_reg == 3'h0)
      |=> cmd_reg == ($past(rx_d[1]) ^ $past(cmd_resp_invert))) // see RULE3
    else $error("command response interpretation wrong");
  AST_CARRIER: assert property (cas |-> receiver_enable == carrier_sense_pin) // see RULE21
    else $error("carrier auto start not steering receiver");
  AST_COMPRESS: assert property (frame_end && accepted && !sframe && two_ctrl && !c0_reg[0]
      |=> !ctrl_reg[0] && (ctrl_reg[7:5] == $past(c1_reg[3:1]))) // see RULE14
    else $error("compressed control field wrong");

  COV_FRAME: cover property (rx_in.start ##[1:20] rx_frame_end_event);
  COV_DMA_DONE: cover property (dma_req ##1 !dma_req);
  COV_SFRAME: cover property (sup_frame_event);
  COV_EXT: cover property (rxd_strobe && (op == OP_EXT));

endmodule // hdlcam_core
`default_nettype wire

// >>> pkg/hdlcam_pkg.sv
`default_nettype none
package hdlcam_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_MODE = 6'h22;
  localparam logic [5:0] IDX_HIGH_MATCH_FIRST = 6'h26;
  localparam logic [5:0] IDX_HIGH_MATCH_SECOND = 6'h27;
  localparam logic [5:0] IDX_LOW_MATCH_FIRST = 6'h28;
  localparam logic [5:0] IDX_CTRL = 6'h29;
  localparam logic [5:0] IDX_LENL = 6'h2a;
  localparam logic [5:0] IDX_LENH = 6'h2b;
  localparam logic [5:0] IDX_AMH = 6'h30;
  localparam logic [5:0] IDX_AML = 6'h31;
  localparam logic [5:0] IDX_STAT = 6'h32;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_OPS_HI = 7;
  localparam int MODE_OPS_LO = 6;
  localparam int MODE_ADM = 5;
  localparam int MODE_RAC = 3;
  localparam int HIGH_MATCH_FIRST_CRI = 1;
  localparam int HIGH_MATCH_SECOND_MCS = 1;
  localparam int TX_LENGTH_HIGH_DMA = 7;
  localparam int TX_LENGTH_HIGH_NRM = 6;
  localparam int TX_LENGTH_HIGH_CAS = 5;
  localparam int TX_LENGTH_HIGH_XC = 4;
  localparam int STAT_GPIN = 5;
  localparam int STAT_RXEN = 4;
  localparam int STAT_LA = 3;
  localparam int STAT_CMD = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] HIGH_BCAST = 8'hfc;
  localparam logic [7:0] HIGH_CARE = 8'hfc;
  localparam logic [7:0] LOW_CARE = 8'hff;
  localparam logic [12:0] LEN_RST = 13'h0000;
  localparam logic [2:0] CLK_MODE_A = 3'h1;
  localparam logic [2:0] CLK_MODE_B = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_AUTO = 2'b00,
    OP_NONAUTO = 2'b01,
    OP_TRANSP = 2'b10,
    OP_EXT = 2'b11
  } hdlcam_op_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_REQ = 2'b10
  } hdlcam_tx_e;
  typedef struct packed {
    logic start;
    logic valid;
    logic last;
    logic [7:0] data;
  } hdlcam_rx_s;
endpackage
`default_nettype wire

// >>> sim/hdlcam_station.sv
`default_nettype none
module hdlcam_station
  import hdlcam_pkg::*;
(
  input wire logic aclk,
  output hdlcam_rx_s rx_in,
  output logic rxd_bit,
  output logic rxd_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_in = '0;
    rxd_bit = 1'h0;
    rxd_strobe = 1'h0;
  end
  // ---------------------------------------
  // framed bytes, gap idle cycles after each
  // ---------------------------------------
  task automatic send_frame(input logic [7:0] b[$], input int gap);
    @(posedge aclk);
    rx_in <= '{1'h1, 1'h0, 1'h0, ~rx_in.data};
    foreach (b[i]) begin
      @(posedge aclk);
      rx_in <= '{1'h0, 1'h1, 1'h0, b[i]};
      repeat (gap) begin
        @(posedge aclk);
        rx_in <= '{1'h0, 1'h0, 1'h0, ~rx_in.data};
      end
    end
    @(posedge aclk);
    rx_in <= '{1'h0, 1'h0, 1'h1, ~rx_in.data};
    @(posedge aclk);
    rx_in <= '{1'h0, 1'h0, 1'h0, ~rx_in.data};
  endtask
  // raw line bits, lsb first
  task automatic send_raw(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      rxd_bit <= v[i];
      rxd_strobe <= 1'h1;
      @(posedge aclk);
      rxd_bit <= ~v[i];
      rxd_strobe <= 1'h0;
    end
  endtask
endmodule // hdlcam_station
`default_nettype wire

// >>> sim/testbench.sv
`default_nettype none
module testbench;
  import hdlcam_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, carrier, ifc, tfc, dma_ack;
  logic awready, wready, bvalid, arready, rvalid, dma_req, rx_en, hdr, qwr, rxd_bit, rxd_strobe;
  logic rfe, sfe;
  int n_sup = 0;
  logic [7:0] awaddr, araddr, qdata, a, c0, c1, e;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] clock_mode;
  hdlcam_rx_s rx_in;
  logic [33:0] expq[$];
  int n_errors = 0;
  int compares = 0;
  int n;
  hdlcam_core u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rx_in(rx_in), .rxd_bit(rxd_bit), .rxd_strobe(rxd_strobe), .carrier_sense_pin(carrier),
    .clock_mode(clock_mode), .tx_info_frame_cmd(ifc), .tx_transparent_frame_cmd(tfc),
    .dma_ack(dma_ack), .dma_req(dma_req), .receiver_enable(rx_en),
    .half_duplex_response(hdr), .rx_frame_end_event(rfe), .sup_frame_event(sfe),
    .rx_queue_wr(qwr), .rx_queue_data(qdata));
  hdlcam_station u_peer (.aclk(aclk), .rx_in(rx_in), .rxd_bit(rxd_bit),
    .rxd_strobe(rxd_strobe));
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // ---------------------------------------
  // checking
  // ---------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pop(input logic [33:0] got);
    chk(got, expq.size() != 0 ? expq.pop_front() : ~got);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) pop({rresp, rdata});
    if (qwr) pop({26'h0, qdata});
    if (qwr || rfe) chk({32'h0, qwr, rfe}, 34'h3);
    if (sfe) n_sup++;
  end
  task automatic give_verdict;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end
  // ---------------------------------------
  // bus and transmit drivers
  // ---------------------------------------
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic aw, w;
    logic ta, tw;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && awready;
      tw = w && wready;
      @(posedge aclk);
      aw = aw && !ta;
      w = w && !tw;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
    expq.push_back({r, 24'h00_0000, v});
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task automatic dma(input logic t, input int x);
    int k;
    @(posedge aclk);
    ifc <= !t;
    tfc <= t;
    @(posedge aclk);
    ifc <= 1'h0;
    tfc <= 1'h0;
    k = 0;
    @(negedge aclk);
    while (dma_req && k < 20) begin
      @(posedge aclk);
      dma_ack <= 1'h1;
      @(posedge aclk);
      dma_ack <= 1'h0;
      k++;
      @(negedge aclk);
    end
    chk(34'(k), 34'(x));
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, carrier, ifc, tfc, dma_ack} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    clock_mode = 3'h0;
    aresetn = 1'h0;
    void'($urandom(38));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(IDX_LENH, 8'h00);
    rd(IDX_CTRL, 8'h00);
    rd(6'h3f, 8'h00, RESP_SLVERR);
    $display("test reset done");
    wr(IDX_LENH, 8'he0);
    rd(IDX_LENH, 8'he0);
    @(posedge aclk);
    carrier <= 1'h1;
    @(negedge aclk);
    chk({33'h0, rx_en}, 34'h1);
    chk({33'h0, hdr}, 34'h1);
    wr(IDX_LENH, 8'h00);
    @(negedge aclk);
    chk({32'h0, hdr, rx_en}, 34'h0);
    rd(IDX_STAT, 8'h23);
    @(posedge aclk);
    clock_mode <= CLK_MODE_A;
    rd(IDX_STAT, 8'h03);
    $display("test transfer mode done");
    a = 8'($urandom);
    wr(IDX_MODE, 8'h08);
    wr(IDX_HIGH_MATCH_FIRST, 8'h00);
    wr(IDX_LOW_MATCH_FIRST, a);
    wr(IDX_CTRL, ~a);
    rd(IDX_LOW_MATCH_FIRST, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_HIGH_MATCH_SECOND, m[0] ? 8'h02 : 8'h00);
      c0 = 8'($urandom) & 8'hfe;
      c1 = 8'($urandom);
      e = m[0] ? {c1[3:1], c1[0], c0[3:1], 1'h0} : c0;
      expq.push_back({26'h0, e});
      u_peer.send_frame({a, c0, c1}, m);
      rd(IDX_CTRL, e);
      rd(IDX_LENL, 8'h03);
    end
    u_peer.send_frame({a, 8'h01, 8'h00}, 0);
    rd(IDX_CTRL, e);
    expq.push_back({26'h0, 8'h03});
    u_peer.send_frame({~a, 8'h03, 8'h55}, 0);
    rd(IDX_CTRL, 8'h03);
    u_peer.send_frame({a ^ 8'h81, 8'h03, 8'h00}, 0);
    wr(IDX_AML, 8'h81);
    expq.push_back({26'h0, 8'h13});
    u_peer.send_frame({a ^ 8'h81, 8'h13, 8'h00}, 0);
    wr(IDX_MODE, 8'h28);
    wr(IDX_HIGH_MATCH_FIRST, 8'h42);
    expq.push_back({26'h0, 8'h03});
    u_peer.send_frame({8'h40, a, 8'h03, 8'h00}, 0);
    rd(IDX_STAT, 8'h1e);
    $display("test address match done");
    c0 = 8'($urandom);
    c1 = 8'($urandom);
    wr(IDX_MODE, 8'h88);
    expq.push_back({26'h0, c1});
    u_peer.send_frame({c0, c1, 8'h5a}, 1);
    wr(IDX_LOW_MATCH_FIRST, ~c0);
    rd(IDX_LOW_MATCH_FIRST, c0);
    wr(IDX_MODE, 8'hc0);
    u_peer.send_raw(c1);
    rd(IDX_LOW_MATCH_FIRST, c1);
    $display("test transparent done");
    n = $urandom_range(6);
    wr(IDX_LENL, n[7:0]);
    wr(IDX_LENH, 8'h80);
    dma(1'h0, n + 1);
    dma(1'h1, n + 1);
    wr(IDX_LENH, 8'h90);
    dma(1'h0, 20);
    wr(IDX_LENH, 8'h00);
    @(negedge aclk);
    chk({33'h0, dma_req}, 34'h0);
    $display("test dma done");
    chk(34'(n_sup), 34'h1);
    chk(34'(expq.size()), 34'h0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
